/* logic/dacc_core.sv */
`timescale 1ns/1ns
// Functional notes
// RL1: Control bit 0 switches the converter on when set, off when cleared.
// RL2: While enabled, each data write starts a conversion at once.
// RL3: While disabled, data write only stores; conversion starts on enable.
// RL4: Control bit 6 powers output buffer and routes output to pin.
// RL5: Internal comparator and converter see output whenever enabled.
// RL6: Bit 7 set with clock running keeps converter active in standby.
// RL7: Bit 7 clear: standby stops conversion, converter and buffer off.
// RL8: After standby, converter and buffer return after a start-up wait; here pin_buffer_on is back next cycle, conversions and internal_out_valid wait.
// RL9: Power-down sleep always turns converter and buffer off.
// RL10: Data register at offset 1 is 8-bit read/write, reset zero.
// RL11: Debug halt leaves converter state and output unchanged.
// RL12: Only instance zero has a pin output driver.
// RL13: Software sets reference, output usage, data, then enables last.
// RL14: Control bits 5 to 1 read zero and ignore writes.
// RL15: No interrupts, no events, no change protection.
module dacc_core
  import dacc_pkg::*;
#(
  parameter int INSTANCE = 0
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [31:0] wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  input  wire logic [3:0]  wb_sel_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        sleep_standby,
  input  wire logic        sleep_powerdown,
  input  wire logic        per_clk_running,
  input  wire logic        debug_halt,
  output logic             core_power,
  output logic             pin_buffer_on,
  output logic             internal_out_valid,
  output logic [7:0]       conversion_level,
  output logic             conversion_start
);

  dacc_state_s           r;
  dacc_state_s           next_r;

  logic                  cyc_stb;
  logic                  sel_low;
  logic                  req;
  logic                  wr;
  logic                  rd;
  logic [1:0]            idx;
  logic [7:0]            wdata_byte;
  logic                  upper_zero;
  logic                  aligned;
  logic                  in_map;
  logic                  hit_control;
  logic                  hit_value;
  logic                  hit_status;
  logic                  read_control;
  logic                  read_value;
  logic                  read_status;
  logic                  wr_control;
  logic                  wr_value;

  logic [7:0]            control_in;
  logic [7:0]            control_next;
  logic                  enable_bit;
  logic                  pin_bit;
  logic                  keep_bit;
  logic                  enable_rise;
  logic                  keep_running;
  logic                  standby_stop;
  logic                  powerdown_stop;
  logic                  want_on;
  logic                  pin_allowed;

  logic                  cnt_done;
  logic [DACC_CNT_W-1:0] cnt_inc;
  logic                  pend_set;
  logic                  pend_now;
  logic                  in_off;
  logic                  in_startup;
  logic                  in_run;
  logic                  go_startup;
  logic                  go_run;
  logic                  cnt_step;
  logic                  load_level;
  logic                  will_run;

  logic                  status_core;
  logic                  status_run;
  logic                  status_pend;
  logic [7:0]            status_word;

  assign cyc_stb = wb_cyc_i
    && wb_stb_i;

  assign sel_low = wb_sel_i[0];

  // Ack is low when a request is taken, so a held strobe is answered every other cycle
  assign req = cyc_stb
    && !r.wb_ack;

  assign wr = req
    && wb_we_i
    && sel_low;

  assign rd = req
    && !wb_we_i;

  assign idx = wb_adr_i[3:2];

  assign wdata_byte = wb_dat_i[7:0];

  assign upper_zero = (wb_adr_i[31:4] == 28'h000_0000);

  assign aligned = (wb_adr_i[1:0] == 2'h0);

  // Unmapped words are still acked so a stray access cannot hang the bus
  assign in_map = upper_zero
    && aligned;

  assign hit_control = in_map
    && (idx == DACC_IDX_CONTROL);

  assign hit_value = in_map
    && (idx == DACC_IDX_VALUE);

  assign hit_status = in_map
    && (idx == DACC_IDX_STATUS);

  assign read_control = rd
    && hit_control;

  assign read_value = rd
    && hit_value;

  assign read_status = rd
    && hit_status;

  assign wr_control = wr
    && hit_control;

  assign wr_value = wr
    && hit_value; // RL10

  // Reserved control bits are cut per bit before they reach any state
  for (genvar b = 0; b < 8; b++) begin : g_ctrl_bit
    if (DACC_CTRL_MASK[b]) begin : g_used
      assign control_in[b] = wdata_byte[b]; // RL1 RL4 RL6
    end else begin : g_reserved
      assign control_in[b] = 1'b0; // RL14
    end
  end

  // Control word as it stands once this cycle's write has landed
  assign control_next = wr_control
    ? control_in
    : r.control; // RL1

  assign enable_bit = control_next[DACC_BIT_ENABLE]; // RL1

  assign pin_bit = control_next[DACC_BIT_PIN_BUF]; // RL4

  assign keep_bit = control_next[DACC_BIT_KEEP]; // RL6

  // Writing a one to enable asks for a conversion, even when already on
  assign enable_rise = wr_control
    && wdata_byte[DACC_BIT_ENABLE]; // RL3

  // The keep bit only helps while the peripheral clock still runs
  assign keep_running = keep_bit
    && per_clk_running; // RL6

  assign standby_stop = sleep_standby
    && !keep_running; // RL7

  assign powerdown_stop = sleep_powerdown; // RL9

  // Debug halt is no input to this: the converter runs on through it
  assign want_on = enable_bit // RL1 RL11
    && !powerdown_stop // RL9
    && !standby_stop; // RL7

  // Only the first instance has a pin driver at all
  assign pin_allowed = (INSTANCE == 0); // RL12

  assign cnt_done = (r.cnt == DACC_CNT_W'(DACC_STARTUP_CYC - 1)); // RL8

  assign cnt_inc = r.cnt + 1'b1;

  assign in_off = (r.mode == DACC_OFF);

  assign in_startup = (r.mode == DACC_STARTUP);

  assign in_run = (r.mode == DACC_RUN);

  // A stop keeps pending data, so it converts after the next start-up
  assign pend_set = wr_value
    || enable_rise; // RL2 RL3

  assign pend_now = r.pending
    || pend_set; // RL3

  assign go_startup = in_off
    && want_on; // RL8

  assign go_run = in_startup
    && want_on
    && cnt_done; // RL8

  assign cnt_step = in_startup
    && want_on
    && !cnt_done; // RL8

  assign load_level = in_run
    && want_on
    && pend_now; // RL2

  assign will_run = go_run
    || (in_run && want_on); // RL5

  assign status_core = r.core_on;

  assign status_run = in_run;

  assign status_pend = r.pending;

  assign status_word = {5'h00,
    status_pend,
    status_run,
    status_core};

  always_comb begin
    next_r = r;
    next_r.wb_ack = req;
    next_r.start = 1'b0;
    next_r.control = control_next; // RL14

    if (wr_value) begin
      next_r.value = wdata_byte; // RL10
    end

    if (load_level) begin
      next_r.pending = 1'b0;
    end else if (pend_set) begin
      next_r.pending = 1'b1; // RL2 RL3
    end

    unique case (r.mode)
      DACC_OFF: begin
        if (go_startup) begin
          next_r.mode = DACC_STARTUP; // RL8
          next_r.cnt = '0;
        end
      end

      DACC_STARTUP: begin
        if (!want_on) begin
          next_r.mode = DACC_OFF; // RL7 RL9
        end else if (go_run) begin
          next_r.mode = DACC_RUN; // RL8
        end else if (cnt_step) begin
          next_r.cnt = cnt_inc;
        end
      end

      DACC_RUN: begin
        if (!want_on) begin
          next_r.mode = DACC_OFF; // RL7 RL9
        end else if (load_level) begin
          next_r.level = next_r.value; // RL2
          next_r.start = 1'b1; // RL2
        end
      end

      default: begin
        next_r.mode = DACC_OFF;
      end
    endcase

    next_r.core_on = want_on; // RL1 RL9
    next_r.internal_on = will_run; // RL5
    // Buffer follows core power so it drops in sleep as well
    next_r.buf_on = want_on
      && pin_bit
      && pin_allowed; // RL4 RL8 RL12

    // No interrupt or event lines and no unlock sequence exist here
    next_r.rdata = 32'h0000_0000; // RL15
    if (read_control) begin
      next_r.rdata = {24'h00_0000,
        r.control}; // RL14
    end

    if (read_value) begin
      next_r.rdata = {24'h00_0000,
        r.value}; // RL10
    end

    if (read_status) begin
      next_r.rdata = {24'h00_0000,
        status_word};
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      r.wb_ack <= 1'b0;
      r.control <= DACC_CONTROL_RST;
      r.value <= DACC_VALUE_RST;
      r.level <= DACC_VALUE_RST;
      r.pending <= 1'b0;
      r.mode <= DACC_OFF;
      r.cnt <= '0;
      r.core_on <= 1'b0;
      r.buf_on <= 1'b0;
      r.internal_on <= 1'b0;
      r.start <= 1'b0;
      r.rdata <= 32'h0000_0000;
    end else begin
      r <= next_r;
    end
  end

  assign wb_dat_o = r.rdata;

  assign wb_ack_o = r.wb_ack;

  assign core_power = r.core_on;

  assign pin_buffer_on = r.buf_on;

  assign internal_out_valid = r.internal_on;

  assign conversion_level = r.level;

  assign conversion_start = r.start;

endmodule : dacc_core

/* pkg/dacc_pkg.sv */
package dacc_pkg;

  // Register indices (printed offsets); byte address is four times the index
  localparam logic [1:0] DACC_IDX_CONTROL = 2'h0;
  localparam logic [1:0] DACC_IDX_VALUE   = 2'h1;
  localparam logic [1:0] DACC_IDX_STATUS  = 2'h2;

  // Control field positions
  localparam int DACC_BIT_ENABLE  = 0;
  localparam int DACC_BIT_PIN_BUF = 6;
  localparam int DACC_BIT_KEEP    = 7;
  localparam logic [7:0] DACC_CTRL_MASK = 8'h00_C1;

  // Reset values
  localparam logic [7:0] DACC_CONTROL_RST = 8'h00_00;
  localparam logic [7:0] DACC_VALUE_RST   = 8'h00_00;

  // Start-up interval before a conversion after power-up, in ns
  localparam int DACC_STARTUP_NS = 1000;
  localparam int DACC_CLK_NS     = 8;
  localparam int DACC_STARTUP_CYC =
    (DACC_STARTUP_NS + DACC_CLK_NS - 1) / DACC_CLK_NS;
  localparam int DACC_CNT_W = 8;

  typedef enum logic [1:0] {
    DACC_OFF,
    DACC_STARTUP,
    DACC_RUN
  } dacc_mode_e;

  typedef struct packed {
    logic       wb_ack;
    logic [7:0] control;
    logic [7:0] value;
    logic [7:0] level;
    logic       pending;
    dacc_mode_e mode;
    logic [DACC_CNT_W-1:0] cnt;
    logic       core_on;
    logic       buf_on;
    logic       internal_on;
    logic       start;
    logic [31:0] rdata;
  } dacc_state_s;

endpackage : dacc_pkg

/* verification/dacc_chk.sv */
`timescale 1ns/1ns
module dacc_chk
  import dacc_pkg::*;
(
  input logic        clk,
  input logic        rst_n,
  input logic        wb_cyc_i,
  input logic        wb_stb_i,
  input logic        wb_we_i,
  input logic [31:0] wb_adr_i,
  input logic [3:0]  wb_sel_i,
  input logic        wb_ack_o,
  input logic        sleep_standby,
  input logic        sleep_powerdown,
  input logic        per_clk_running,
  input logic        core_power,
  input logic        pin_buffer_on,
  input logic        internal_out_valid,
  input logic [7:0]  conversion_level,
  input logic        conversion_start
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence data_wr;
    wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i && wb_sel_i[0]
      && wb_adr_i[3:2] == DACC_IDX_VALUE;
  endsequence
  ack_once_a: assert property (
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
    else $error("ack width");
  pdn_off_a: assert property (
    sleep_powerdown |=> !core_power && !pin_buffer_on) else $error("pdn");
  stby_off_a: assert property (
    sleep_standby && !per_clk_running |=> !core_power) else $error("stby");
  buf_core_a: assert property (pin_buffer_on |-> core_power)
    else $error("buf");
  int_core_a: assert property (internal_out_valid |-> core_power)
    else $error("int");
  lvl_cause_a: assert property (
    $changed(conversion_level) |-> conversion_start) else $error("lvl");
  wr_start_a: assert property (
    data_wr ##0 (internal_out_valid && !sleep_powerdown && !sleep_standby)
      |=> conversion_start) else $error("wr");
  warm_up_a: assert property (
    $rose(core_power) |-> !internal_out_valid [*8]) else $error("warm");
endmodule : dacc_chk
bind dacc_core dacc_chk u_dacc_chk (.*);

/* verification/dacc_far.sv */
`timescale 1ns/1ns
module dacc_far (
  input  logic       clk,
  input  logic       go,
  input  logic [7:0] lvl,
  output logic [7:0] seen
);
  // Analog side follows the level only when a conversion starts
  always_ff @(posedge clk) if (go) seen <= lvl;
endmodule : dacc_far

/* verification/tb.sv */
`timescale 1ns/1ns
module tb import dacc_pkg::*; ;
  logic clk = 0, rst_n = 0, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
  logic [31:0] wb_adr_i = '0, wb_dat_i = '0, wb_dat_o, q;
  logic [3:0] wb_sel_i = 4'h1;
  logic wb_ack_o, sleep_standby = 0, sleep_powerdown = 0, debug_halt = 0;
  logic per_clk_running = 1, core_power, pin_buffer_on, conversion_start;
  logic internal_out_valid;
  logic [7:0] conversion_level, seen;
  int num_errors = 0, total_checks = 0, nst = 0, ncyc = 0;
  always #4 clk = ~clk;
  dacc_core u_dacc_core (.*);
  dacc_far u_dacc_far (.clk, .go(conversion_start), .lvl(conversion_level),
    .seen);
  task summarize;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : summarize
  task chk(input string s, input logic [31:0] g, e);
    total_checks++;
    if (g !== e) begin
      num_errors++;
      $display("[FAIL] %s exp %h got %h", s, e, g);
    end
  endtask : chk
  // Slave answer time is not assumed; only the cycle ceiling ends a wait
  task bus(input logic w, input logic [31:0] a, d);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'h3, w, a, d};
    @(posedge clk);
    while (wb_ack_o !== 1'h1) @(posedge clk);
    q = wb_dat_o;
    {wb_cyc_i, wb_stb_i} <= '0;
    @(posedge clk);
  endtask : bus
  always @(posedge clk) begin
    nst <= nst + (conversion_start === 1'h1);
    ncyc <= ncyc + 1;
    if (ncyc == 4000) begin
      num_errors++;
      summarize();
    end
  end
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'h1;
    @(posedge clk);
    bus(1'h0, '0, '0);
    chk("control", q, '0);
    bus(1'h1, 32'h4, 32'h5A);
    bus(1'h1, 32'hFF, 32'hFF);
    chk("start", nst, '0);
    bus(1'h1, '0, 32'hFF);
    bus(1'h0, '0, '0);
    chk("mask", q, 32'hC1);
    repeat (DACC_STARTUP_CYC + 4) @(posedge clk);
    chk("pend", nst, 32'h1);
    chk("seen", seen, 32'h5A);
    chk("pin", pin_buffer_on, 32'h1);
    bus(1'h1, 32'h4, 32'hA5);
    bus(1'h0, 32'h4, '0);
    chk("value", q, 32'hA5);
    chk("conv", seen, 32'hA5);
    bus(1'h0, 32'h10, '0);
    chk("unmap", q, '0);
    $display("test registers done");
    {debug_halt, sleep_standby} <= 2'h3;
    repeat (4) @(posedge clk);
    chk("keep", core_power, 32'h1);
    chk("halt", conversion_level, 32'hA5);
    per_clk_running <= 1'h0;
    repeat (3) @(posedge clk);
    chk("stop", core_power, '0);
    {sleep_standby, per_clk_running} <= 2'h1;
    repeat (3) @(posedge clk);
    chk("warm", internal_out_valid, '0);
    repeat (DACC_STARTUP_CYC + 4) @(posedge clk);
    chk("wake", internal_out_valid & pin_buffer_on, 32'h1);
    bus(1'h0, 32'h8, '0);
    chk("status", q, 32'h3);
    sleep_powerdown <= 1'h1;
    repeat (3) @(posedge clk);
    chk("pdn", core_power, '0);
    sleep_powerdown <= 1'h0;
    bus(1'h1, '0, '0);
    chk("off", core_power, '0);
    $display("test sleep done");
    summarize();
  end
endmodule : tb
